/* hw/sfrh_top.sv */
// Serial read path with pause control in front of a byte array.
// Behaviour
// - Two address bytes follow; a 15-bit start address is taken.
// - Top bit of the two address bytes is dropped.
// - After command and address, the addressed byte goes out over eight clocks.
// - Serial input is ignored while read data is shifted out.
// - Address advances after each byte while selected and clocked.
// - Address wraps from the last location to the first.
// - Each byte goes out most significant bit first.
// - Chip select rising floats the serial output and ends the read, except while hold is low.
// - Hold suspends the transfer and keeps its state for later.
// - Hold low with clock low freezes bit position and address.
// - Hold high with clock low resumes from where it stopped.
// - Clock and chip select toggling during hold leave the paused state intact.
`timescale 1ns/10ps
`default_nettype none

module sfrh_top #(
  parameter logic [sfrh_pkg::DATA_W-1:0] READ_OPCODE = sfrh_pkg::READ_OPCODE_DFLT,
  parameter int MEM_DEPTH = sfrh_pkg::MEM_DEPTH
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Array load port
  input wire sfrh_pkg::sfrh_wr_t load_i,
  // Transaction status
  output sfrh_pkg::sfrh_stat_t stat_o,
  output logic stat_start_pulse,
  output logic stat_byte_pulse,
  // Serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic spi_hold_n,
  output logic spi_so,
  output logic spi_so_oe
);

  // ==========================================================================
  // Link-side state
  sfrh_pkg::sfrh_phase_t phase_q;
  logic [sfrh_pkg::BIT_CNT_W-1:0] bit_cnt_q;
  logic [sfrh_pkg::DATA_W-1:0] sh_in_q;
  logic [sfrh_pkg::ADDR_W-1:0] addr_q;
  logic [sfrh_pkg::DATA_W-1:0] out_q;
  logic drive_q;
  logic rd_active_q;
  logic start_tgl_q;
  logic byte_tgl_q;
  logic [sfrh_pkg::ADDR_W-1:0] start_addr_q;

  logic spi_rst;
  logic byte_done;
  logic [sfrh_pkg::DATA_W-1:0] byte_in;
  logic [sfrh_pkg::DATA_W-1:0] rd_data;

  // ==========================================================================
  // System-side state
  logic [sfrh_pkg::SYNC_W-1:0] sync_in;
  logic [sfrh_pkg::SYNC_W-1:0] sync_out;
  logic start_prev_q;
  logic byte_prev_q;
  logic start_pulse;
  logic byte_pulse;
  logic busy_q;
  logic held_q;
  logic [sfrh_pkg::ADDR_W-1:0] sys_start_addr_q;
  logic [sfrh_pkg::CNT_W-1:0] byte_cnt_q;
  logic start_pulse_q;
  logic byte_pulse_q;

  // ==========================================================================
  // Frame reset
  // Deselect clears the frame, but not while held, so a chip select
  // wiggle during a pause cannot destroy the suspended transfer.
  assign spi_rst = sys_rst | (spi_cs_n & spi_hold_n);

  // The byte as it stands after the current rising edge
  assign byte_in = {sh_in_q[sfrh_pkg::DATA_W-2:0], spi_si};
  assign byte_done = (bit_cnt_q == sfrh_pkg::BIT_LAST);

  // ==========================================================================
  // Bit position
  // Hold only changes while the clock is low, so its level at a rising
  // edge is stable and gating on it freezes everything cleanly.
  always_ff @(posedge spi_sck or posedge spi_rst) begin
    if (spi_rst) begin
      bit_cnt_q <= sfrh_pkg::BIT_FIRST;
    end else if (spi_hold_n) begin
      if (phase_q != sfrh_pkg::SFRH_PH_IGNORE) begin
        bit_cnt_q <= bit_cnt_q + sfrh_pkg::BIT_CNT_W'(1);
      end
    end
  end

  // ==========================================================================
  // Transaction phase
  always_ff @(posedge spi_sck or posedge spi_rst) begin
    if (spi_rst) begin
      phase_q <= sfrh_pkg::SFRH_PH_CMD;
    end else if (spi_hold_n && byte_done) begin
      case (phase_q)
        sfrh_pkg::SFRH_PH_CMD: begin
          // Commands other than read are not served here
          if (byte_in == READ_OPCODE) begin
            phase_q <= sfrh_pkg::SFRH_PH_ADDR_HI;
          end else begin
            phase_q <= sfrh_pkg::SFRH_PH_IGNORE;
          end
        end
        sfrh_pkg::SFRH_PH_ADDR_HI: begin
          phase_q <= sfrh_pkg::SFRH_PH_ADDR_LO;
        end
        sfrh_pkg::SFRH_PH_ADDR_LO: begin
          phase_q <= sfrh_pkg::SFRH_PH_DATA;
        end
        sfrh_pkg::SFRH_PH_DATA: begin
          phase_q <= sfrh_pkg::SFRH_PH_DATA;
        end
        default: begin
          phase_q <= sfrh_pkg::SFRH_PH_IGNORE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Input shifter
  always_ff @(posedge spi_sck or posedge spi_rst) begin
    if (spi_rst) begin
      sh_in_q <= '0;
    end else if (spi_hold_n) begin
      if (phase_q != sfrh_pkg::SFRH_PH_DATA) begin
        sh_in_q <= byte_in;
      end
    end
  end

  // ==========================================================================
  // Address counter
  always_ff @(posedge spi_sck or posedge spi_rst) begin
    if (spi_rst) begin
      addr_q <= sfrh_pkg::ADDR_ZERO;
    end else if (spi_hold_n && byte_done) begin
      case (phase_q)
        sfrh_pkg::SFRH_PH_ADDR_HI: begin
          // Top bit of the high byte carries no address
          addr_q[sfrh_pkg::ADDR_W-1:sfrh_pkg::ADDR_LO_W] <=
            byte_in[sfrh_pkg::ADDR_HI_W-1:0];
        end
        sfrh_pkg::SFRH_PH_ADDR_LO: begin
          addr_q[sfrh_pkg::ADDR_LO_W-1:0] <= byte_in;
        end
        sfrh_pkg::SFRH_PH_DATA: begin
          // Natural 15-bit overflow gives the wrap to the first location
          addr_q <= addr_q + sfrh_pkg::ADDR_STEP;
        end
        default: begin
          addr_q <= addr_q;
        end
      endcase
    end
  end

  // ==========================================================================
  // Read in progress flag
  always_ff @(posedge spi_sck or posedge spi_rst) begin
    if (spi_rst) begin
      rd_active_q <= 1'b0;
    end else if (spi_hold_n && byte_done && (phase_q == sfrh_pkg::SFRH_PH_ADDR_LO)) begin
      rd_active_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Events toward the system domain
  // These survive deselect; a frame reset would break the toggle protocol.
  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      start_tgl_q <= 1'b0;
      start_addr_q <= sfrh_pkg::ADDR_ZERO;
    end else if (spi_hold_n && !spi_cs_n && byte_done &&
                 (phase_q == sfrh_pkg::SFRH_PH_ADDR_LO)) begin
      start_tgl_q <= ~start_tgl_q;
      start_addr_q <= {addr_q[sfrh_pkg::ADDR_W-1:sfrh_pkg::ADDR_LO_W], byte_in};
    end
  end

  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      byte_tgl_q <= 1'b0;
    end else if (spi_hold_n && !spi_cs_n && byte_done &&
                 (phase_q == sfrh_pkg::SFRH_PH_DATA)) begin
      byte_tgl_q <= ~byte_tgl_q;
    end
  end

  // ==========================================================================
  // Array
  sfrh_mem #(
    .DEPTH(MEM_DEPTH)
  ) u_mem (
    .wr_clk(sys_clk),
    .wr_i(load_i),
    .rd_addr(addr_q),
    .rd_data(rd_data)
  );

  // ==========================================================================
  // Output shifter, falling edge
  // Loading on the falling edge gives the master half a clock of setup
  // in mode 0 and covers mode 3 without a separate path.
  always_ff @(negedge spi_sck or posedge spi_rst) begin
    if (spi_rst) begin
      out_q <= '0;
      drive_q <= 1'b0;
    end else if (spi_hold_n && (phase_q == sfrh_pkg::SFRH_PH_DATA)) begin
      drive_q <= 1'b1;
      if (bit_cnt_q == sfrh_pkg::BIT_FIRST) begin
        out_q <= rd_data;
      end else begin
        out_q <= {out_q[sfrh_pkg::DATA_W-2:0], 1'b0};
      end
    end
  end

  assign spi_so = out_q[sfrh_pkg::DATA_W-1];
  // Enable follows the pins directly so hold and deselect float at once
  assign spi_so_oe = drive_q & ~spi_cs_n & spi_hold_n;

  // ==========================================================================
  // Crossing into the system domain
  assign sync_in = {rd_active_q, ~spi_hold_n, start_tgl_q, byte_tgl_q};

  sfrh_sync #(
    .W(sfrh_pkg::SYNC_W)
  ) u_sync (
    .clk(sys_clk),
    .rst(sys_rst),
    .async_i(sync_in),
    .sync_o(sync_out)
  );

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_prev_q <= 1'b0;
      byte_prev_q <= 1'b0;
    end else begin
      start_prev_q <= sync_out[1];
      byte_prev_q <= sync_out[0];
    end
  end

  assign start_pulse = sync_out[1] ^ start_prev_q;
  assign byte_pulse = sync_out[0] ^ byte_prev_q;

  // ==========================================================================
  // System-side status
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      busy_q <= sync_out[3];
      held_q <= sync_out[2];
    end
  end

  // Start address is stable here: it only moves at the next start event
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_start_addr_q <= sfrh_pkg::ADDR_ZERO;
    end else if (start_pulse) begin
      sys_start_addr_q <= start_addr_q;
    end
  end

  // A byte that lands with the start still counts
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_cnt_q <= sfrh_pkg::CNT_ZERO;
    end else if (start_pulse) begin
      byte_cnt_q <= byte_pulse ? sfrh_pkg::CNT_ONE : sfrh_pkg::CNT_ZERO;
    end else if (byte_pulse) begin
      byte_cnt_q <= byte_cnt_q + sfrh_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_pulse_q <= 1'b0;
      byte_pulse_q <= 1'b0;
    end else begin
      start_pulse_q <= start_pulse;
      byte_pulse_q <= byte_pulse;
    end
  end

  assign stat_o.busy = busy_q;
  assign stat_o.held = held_q;
  assign stat_o.start_addr = sys_start_addr_q;
  assign stat_o.byte_cnt = byte_cnt_q;
  assign stat_start_pulse = start_pulse_q;
  assign stat_byte_pulse = byte_pulse_q;

endmodule : sfrh_top

`default_nettype wire

/* hw/sfrh_pkg.sv */
// Shared constants and carrier types of the serial array read path.
package sfrh_pkg;

  // ==========================================================================
  // Array geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 32768;
  localparam int ADDR_HI_W = 7;
  localparam int ADDR_LO_W = 8;

  // ==========================================================================
  // Serial framing
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
  // Opcode value is a plain default, kept overridable at the top
  localparam logic [DATA_W-1:0] READ_OPCODE_DFLT = 8'h03;

  // ==========================================================================
  // System side
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam int SYNC_W = 4;

  typedef enum logic [2:0] {
    SFRH_PH_CMD,
    SFRH_PH_ADDR_HI,
    SFRH_PH_ADDR_LO,
    SFRH_PH_DATA,
    SFRH_PH_IGNORE
  } sfrh_phase_t;

  // Array load port in the system domain
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sfrh_wr_t;

  // Transaction status seen in the system domain
  typedef struct packed {
    logic busy;
    logic held;
    logic [ADDR_W-1:0] start_addr;
    logic [CNT_W-1:0] byte_cnt;
  } sfrh_stat_t;

endpackage : sfrh_pkg

/* hw/sfrh_sync.sv */
// Two flip-flop level synchroniser, one lane per bit.
`timescale 1ns/10ps
`default_nettype none

module sfrh_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : sfrh_sync

`default_nettype wire

/* hw/sfrh_mem.sv */
// Byte array with a system-clock load port and a combinational read port.
`timescale 1ns/10ps
`default_nettype none

module sfrh_mem #(
  parameter int DEPTH = sfrh_pkg::MEM_DEPTH
) (
  // Load side
  input wire logic wr_clk,
  input wire sfrh_pkg::sfrh_wr_t wr_i,
  // Read side
  input wire logic [sfrh_pkg::ADDR_W-1:0] rd_addr,
  output logic [sfrh_pkg::DATA_W-1:0] rd_data
);

  logic [sfrh_pkg::DATA_W-1:0] mem_q [DEPTH];

  // ==========================================================================
  // Storage has no reset; contents are undefined until loaded
  always_ff @(posedge wr_clk) begin
    if (wr_i.wr) begin
      mem_q[wr_i.addr] <= wr_i.data;
    end
  end

  // Read is unclocked so a byte is ready on the next serial falling edge
  assign rd_data = mem_q[rd_addr];

endmodule : sfrh_mem

`default_nettype wire

/* tb/sfrh_chk.sv */
// Port checks of the serial read path.
`timescale 1ns/10ps
`default_nettype none

module sfrh_chk #(
  parameter logic [sfrh_pkg::DATA_W-1:0] READ_OPCODE = sfrh_pkg::READ_OPCODE_DFLT
) (
  // System side
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire sfrh_pkg::sfrh_stat_t stat_o,
  input wire logic stat_start_pulse,
  input wire logic stat_byte_pulse,
  // Serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic spi_hold_n,
  input wire logic spi_so_oe
);
  // ====================
  // Frame rise count; held rises do not count
  logic frm_rst;
  logic [5:0] rise_q;
  logic [7:0] cmd_q;
  assign frm_rst = sys_rst | (spi_cs_n & spi_hold_n);
  always_ff @(posedge spi_sck or posedge frm_rst) begin
    if (frm_rst) begin
      rise_q <= 6'h00;
      cmd_q <= 8'h00;
    end else if (spi_hold_n) begin
      rise_q <= (rise_q == 6'h3f) ? rise_q : rise_q + 6'h01;
      if (rise_q < 6'h08) cmd_q <= {cmd_q[6:0], spi_si};
    end
  end

  // ====================
  // Assertions
  oe_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !spi_hold_n |-> !spi_so_oe) else $error("output driven during hold");
  oe_desel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    spi_cs_n |-> !spi_so_oe) else $error("output driven while deselected");
  oe_early_a: assert property (@(posedge spi_sck) disable iff (sys_rst)
    rise_q < 6'h18 |-> !spi_so_oe) else $error("output driven before address done");
  oe_on_a: assert property (@(posedge spi_sck) disable iff (sys_rst)
    (rise_q >= 6'h18 && cmd_q == READ_OPCODE && spi_hold_n && !spi_cs_n) |-> spi_so_oe)
    else $error("read data not driven");
  oe_refuse_a: assert property (@(posedge spi_sck) disable iff (sys_rst)
    cmd_q != READ_OPCODE |-> !spi_so_oe) else $error("output driven for other opcode");
  start_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    stat_start_pulse |=> !stat_start_pulse) else $error("start pulse too long");
  byte_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    stat_byte_pulse |=> !stat_byte_pulse) else $error("byte pulse too long");
  held_sync_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(spi_hold_n) |-> ##[1:5] stat_o.held) else $error("held flag missing");
endmodule : sfrh_chk

bind sfrh_top sfrh_chk #(.READ_OPCODE(READ_OPCODE)) chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .stat_o(stat_o),
  .stat_start_pulse(stat_start_pulse), .stat_byte_pulse(stat_byte_pulse),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
  .spi_hold_n(spi_hold_n), .spi_so_oe(spi_so_oe)
);
`default_nettype wire

/* tb/sfrh_spi_mst.sv */
// Bus master model for the serial link, 30 ns clock, mode 0.
`timescale 1ns/10ps
`default_nettype none

module sfrh_spi_mst (
  // Driven lines
  output var logic spi_sck,
  output var logic spi_cs_n,
  output var logic spi_si,
  output var logic spi_hold_n,
  // Resolved serial output
  input wire logic so_w
);
  // ====================
  // Clock stands low outside frames
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
    spi_hold_n = 1'b1;
  end

  task automatic open_frame();
    spi_cs_n = 1'b0;
    #15;
  endtask : open_frame

  // Input flipped after release so no stale level lingers
  task automatic close_frame();
    #15;
    spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #60;
  endtask : close_frame

  task automatic xbit(input logic b, output logic r);
    spi_si = b;
    #15;
    r = so_w;
    spi_sck = 1'b1;
    #15;
    spi_sck = 1'b0;
  endtask : xbit

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      xbit(tx[i], rx[i]);
    end
  endtask : xbyte

  // Hold moves only with the clock low
  task automatic hold_set(input logic v);
    #15;
    spi_hold_n = v;
    #15;
  endtask : hold_set

  task automatic wiggle();
    repeat (2) begin
      spi_sck = 1'b1;
      #15;
      spi_sck = 1'b0;
      #15;
    end
    spi_cs_n = 1'b1;
    #30;
    spi_cs_n = 1'b0;
    #15;
  endtask : wiggle
endmodule : sfrh_spi_mst
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the serial read path with pause control.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ====================
  // Signals
  logic sys_clk;
  logic sys_rst;
  sfrh_pkg::sfrh_wr_t load_i;
  sfrh_pkg::sfrh_stat_t stat_o;
  logic stat_start_pulse, stat_byte_pulse;
  logic spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_so, spi_so_oe;
  wire logic so_w;
  int error_cnt, checked, starts, bytes;
  logic [7:0] shadow [logic [14:0]];
  localparam logic [7:0] RD = sfrh_pkg::READ_OPCODE_DFLT;

  assign so_w = spi_so_oe ? spi_so : 1'bz;

  sfrh_top dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .load_i(load_i), .stat_o(stat_o),
    .stat_start_pulse(stat_start_pulse), .stat_byte_pulse(stat_byte_pulse),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_hold_n(spi_hold_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe)
  );
  sfrh_spi_mst mst_u (
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_hold_n(spi_hold_n), .so_w(so_w)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (stat_start_pulse === 1'b1) starts++;
    if (stat_byte_pulse === 1'b1) bytes++;
  end

  // ====================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic load(input logic [14:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    load_i = {1'b1, a, d};
    shadow[a] = d;
    @(posedge sys_clk);
    #1;
    load_i.wr = 1'b0;
  endtask : load

  task automatic head(input logic [7:0] op, input logic [15:0] a);
    logic [7:0] rx;
    mst_u.open_frame();
    mst_u.xbyte(op, rx);
    mst_u.xbyte(a[15:8], rx);
    mst_u.xbyte(a[7:0], rx);
  endtask : head

  // Input toggles during data; the device must not care
  task automatic read_chk(input logic [14:0] a, input int n);
    logic [7:0] rx;
    for (int k = 0; k < n; k++) begin
      mst_u.xbyte(8'h5a ^ k[7:0], rx);
      check("read byte", {8'h00, shadow[a + k[14:0]]}, {8'h00, rx});
    end
  endtask : read_chk

  // ====================
  // Scenarios
  task automatic t_basic();
    int s0;
    int b0;
    load(15'h1234, 8'h1e);
    load(15'h1235, 8'hb4);
    load(15'h1236, 8'h37);
    s0 = starts;
    b0 = bytes;
    head(RD, 16'h9234);
    read_chk(15'h1234, 3);
    check("busy", 16'h0001, {15'h0000, stat_o.busy});
    mst_u.close_frame();
    check("oe off", 16'h0000, {15'h0000, spi_so_oe});
    check("busy off", 16'h0000, {15'h0000, stat_o.busy});
    check("starts", 16'h0001, 16'(starts - s0));
    check("bytes", 16'h0003, 16'(bytes - b0));
    check("start addr", 16'h1234, {1'b0, stat_o.start_addr});
    check("byte cnt", 16'h0003, stat_o.byte_cnt);
    $display("basic read done");
  endtask : t_basic

  task automatic t_wrap();
    load(15'h7fff, 8'h6d);
    load(15'h0000, 8'h4b);
    head(RD, 16'h7fff);
    read_chk(15'h7fff, 2);
    mst_u.close_frame();
    $display("wrap read done");
  endtask : t_wrap

  task automatic t_hold();
    logic [7:0] rx;
    load(15'h0100, 8'hd2);
    load(15'h0101, 8'h2d);
    head(RD, 16'h0100);
    for (int i = 7; i >= 0; i--) begin
      if (i == 4) begin
        mst_u.hold_set(1'b0);
        check("oe held", 16'h0000, {15'h0000, spi_so_oe});
        mst_u.wiggle();
        check("held flag", 16'h0001, {15'h0000, stat_o.held});
        mst_u.hold_set(1'b1);
      end
      mst_u.xbit(1'b1, rx[i]);
    end
    check("held byte", 16'h00d2, {8'h00, rx});
    read_chk(15'h0101, 1);
    check("held off", 16'h0000, {15'h0000, stat_o.held});
    mst_u.close_frame();
    $display("hold read done");
  endtask : t_hold

  task automatic t_badop();
    logic [7:0] rx;
    int s0;
    s0 = starts;
    head(8'h0b, 16'h1234);
    mst_u.xbyte(8'h00, rx);
    check("no drive", 16'h00zz, {8'h00, rx});
    check("no busy", 16'h0000, {15'h0000, stat_o.busy});
    mst_u.close_frame();
    check("no start", 16'h0000, 16'(starts - s0));
    $display("other opcode done");
  endtask : t_badop

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  initial begin
    sys_rst = 1'b1;
    load_i = '0;
    repeat (4) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    t_basic();
    t_wrap();
    t_hold();
    t_badop();
    print_verdict();
  end

  // Tests need a few microseconds; ten times that means a hang
  initial begin
    #50000;
    error_cnt++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
